// ==== tmr8_regs.vh ====
`ifndef TMR8_REGS_VH
`define TMR8_REGS_VH

// Register word addresses
`define TMR8_AW            3
`define TMR8_ADDR_CTRL     3'h0
`define TMR8_ADDR_COUNT    3'h1
`define TMR8_ADDR_COMPARE  3'h2
`define TMR8_ADDR_FLAGS    3'h3
`define TMR8_ADDR_PIN      3'h4

// Control register fields
`define TMR8_CTRL_WM_LO    0
`define TMR8_CTRL_WM_HI    1
`define TMR8_CTRL_COM_LO   2
`define TMR8_CTRL_COM_HI   3
`define TMR8_CTRL_FORCE    7

// Flag register fields
`define TMR8_FLAG_OVF      0
`define TMR8_FLAG_CMP      1

// Pin control register fields
`define TMR8_PIN_DIR       0
`define TMR8_PIN_PORT      1
`define TMR8_PIN_STATE     2

// Waveform modes
`define TMR8_WM_NORMAL     2'h0
`define TMR8_WM_PHASE      2'h1
`define TMR8_WM_CLEAR      2'h2
`define TMR8_WM_FAST       2'h3

// Compare output modes
`define TMR8_COM_OFF       2'h0
`define TMR8_COM_TOGGLE    2'h1
`define TMR8_COM_CLEAR     2'h2
`define TMR8_COM_SET       2'h3

// Counter values and reset values
`define TMR8_MAX           8'hFF
`define TMR8_BOTTOM        8'h00
`define TMR8_ONE           8'h01
`define TMR8_RST_BYTE      8'h00
`define TMR8_RST_MODE      2'h0

`endif

// ==== tmr8_wave.v ====
// Function
// - Reset clears the internal compare output state bit to zero.
// - Nonzero compare output mode routes state to pin; direction bit enables drive.
// - Pin override depends only on compare output mode, not waveform mode.
// - Compare output mode zero leaves output state unchanged on matches.
// - New compare output mode takes effect at the next compare match.
// - Force strobe in non-PWM modes applies the output action immediately.
// - Counting sequence depends only on waveform mode.
// - Mode zero always increments, wraps from 0xFF to 0x00, never clears.
// - Normal mode sets overflow flag when the counter becomes zero.
// - Counter only sets overflow flag; clearing comes from interrupt acknowledge or a one written to the flag bit.
// - Normal mode accepts counter writes at any time.
// - Mode two clears counter on match with compare value as top.
// - Clear-on-match mode sets compare match flag on reaching top.
// - Clear-on-match compare unbuffered; below count means wrap through 0xFF.
// - Clear-on-match with mode one toggles output on every match.
// - Clear-on-match sets overflow flag on passing from maximum to 0x00.
// - Mode three counts to maximum, then clears on next timer tick.
// - Fast PWM non-inverting clears on match, sets at bottom; inverting opposite.
// - Fast PWM sets overflow flag each time the counter passes from maximum to bottom.
// - Fast PWM compare zero gives one-tick spike; maximum gives constant level.
// - Compare register double buffered in PWM, loaded at top; else immediate.
// - Counter equal to compare sets match flag at the next timer tick.
// - Counter write suppresses compare match in the following timer tick.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tmr8_regs.vh"

module tmr8_wave
#(
  parameter DW = 8
)
(
  input  wire                  ref_clk,
  input  wire                  rstn,
  input  wire                  tick_en,
  input  wire [`TMR8_AW-1:0]   bus_addr,
  input  wire [DW-1:0]         bus_wdata,
  input  wire                  bus_wr,
  input  wire                  bus_rd,
  output wire [DW-1:0]         bus_rdata,
  input  wire                  ovf_ack,
  input  wire                  cmp_ack,
  output wire                  overflow_flag,
  output wire                  compare_match_flag,
  output wire                  compare_output_state,
  output wire                  pin_out,
  output wire                  pin_oe
);

  reg [1:0]    waveform_mode_q;
  reg [1:0]    compare_output_mode_q;
  reg [DW-1:0] counter_value_q;
  reg [DW-1:0] counter_value_d;
  reg [DW-1:0] compare_value_q;
  reg [DW-1:0] compare_value_d;
  reg [DW-1:0] compare_buf_q;
  reg [DW-1:0] compare_buf_d;
  reg          block_q;
  reg          block_d;
  reg          ovf_q;
  reg          ovf_d;
  reg          cmp_q;
  reg          cmp_d;
  reg          state_q;
  reg          state_d;
  reg          dir_q;
  reg          port_q;
  reg          pin_out_q;
  reg          pin_oe_q;
  reg [DW-1:0] rdata_q;
  reg [DW-1:0] rdata_d;

  wire wr_ctrl;
  wire wr_count;
  wire wr_compare;
  wire wr_flags;
  wire wr_pin;
  wire force_strobe;
  wire pwm_mode;
  wire at_max;
  wire cmp_equal;
  wire match_hit;
  wire ovf_set;
  wire ovf_clr;
  wire cmp_clr;
  wire override;

  // Action of a non-PWM compare match on the output state
  function wave_action;
    input [1:0] com;
    input       cur;
    begin
      case (com)
        `TMR8_COM_OFF:
          wave_action = cur;
        `TMR8_COM_TOGGLE:
          wave_action = ~cur;
        `TMR8_COM_CLEAR:
          wave_action = 1'b0;
        `TMR8_COM_SET:
          wave_action = 1'b1;
        default:
          wave_action = cur;
      endcase
    end
  endfunction

  // Fast PWM, the only mode that buffers the compare value and shapes PWM output
  function is_pwm;
    input [1:0] wm;
    begin
      is_pwm = (wm == `TMR8_WM_FAST);
    end
  endfunction

  assign wr_ctrl      = bus_wr & (bus_addr == `TMR8_ADDR_CTRL);
  assign wr_count     = bus_wr & (bus_addr == `TMR8_ADDR_COUNT);
  assign wr_compare   = bus_wr & (bus_addr == `TMR8_ADDR_COMPARE);
  assign wr_flags     = bus_wr & (bus_addr == `TMR8_ADDR_FLAGS);
  assign wr_pin       = bus_wr & (bus_addr == `TMR8_ADDR_PIN);
  assign force_strobe = wr_ctrl & bus_wdata[`TMR8_CTRL_FORCE];

  assign pwm_mode  = is_pwm(waveform_mode_q);
  assign at_max    = (counter_value_q == `TMR8_MAX);
  assign cmp_equal = (counter_value_q == compare_value_q);

  // Comparison seen on a tick; flag follows at the same edge
  assign match_hit = tick_en & cmp_equal & ~block_q;

  // Phase-correct mode is not built, so it never flags overflow
  assign ovf_set = tick_en & at_max & (waveform_mode_q != `TMR8_WM_PHASE);
  assign ovf_clr = ovf_ack | (wr_flags & bus_wdata[`TMR8_FLAG_OVF]);
  assign cmp_clr = cmp_ack | (wr_flags & bus_wdata[`TMR8_FLAG_CMP]);

  assign override = |compare_output_mode_q;

  // Counter sequence
  always @*
  begin
    counter_value_d = counter_value_q;
    if (tick_en)
    begin
      case (waveform_mode_q)
        `TMR8_WM_CLEAR:
        begin
          if (match_hit)
            counter_value_d = `TMR8_BOTTOM;
          else
            counter_value_d = counter_value_q + `TMR8_ONE;
        end
        `TMR8_WM_FAST:
        begin
          if (at_max)
            counter_value_d = `TMR8_BOTTOM;
          else
            counter_value_d = counter_value_q + `TMR8_ONE;
        end
        default:
          counter_value_d = counter_value_q + `TMR8_ONE;
      endcase
    end
    // Software write beats any count or clear
    if (wr_count)
      counter_value_d = bus_wdata;
  end

  // Match blocking after a counter write, kept until the next tick
  always @*
  begin
    block_d = block_q;
    if (tick_en)
      block_d = 1'b0;
    if (wr_count)
      block_d = 1'b1;
  end

  // Compare value and its buffer
  always @*
  begin
    compare_buf_d   = compare_buf_q;
    compare_value_d = compare_value_q;
    if (wr_compare)
      compare_buf_d = bus_wdata;
    if (pwm_mode)
    begin
      // Loading at top keeps each PWM period whole
      if (tick_en & at_max)
        compare_value_d = compare_buf_q;
    end
    else
    begin
      if (wr_compare)
        compare_value_d = bus_wdata;
      else
        compare_value_d = compare_buf_q;
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always @*
  begin
    ovf_d = ovf_q;
    if (ovf_clr)
      ovf_d = 1'b0;
    if (ovf_set)
      ovf_d = 1'b1;
    cmp_d = cmp_q;
    if (cmp_clr)
      cmp_d = 1'b0;
    if (match_hit)
      cmp_d = 1'b1;
  end

  // Output state; the mode in force at the match decides the action
  always @*
  begin
    state_d = state_q;
    if (pwm_mode)
    begin
      if (match_hit)
      begin
        case (compare_output_mode_q)
          `TMR8_COM_TOGGLE:
            state_d = ~state_q;
          `TMR8_COM_CLEAR:
            state_d = 1'b0;
          `TMR8_COM_SET:
            state_d = 1'b1;
          default:
            state_d = state_q;
        endcase
      end
      // Bottom action after the match, so compare at max holds a level
      if (tick_en & at_max)
      begin
        case (compare_output_mode_q)
          `TMR8_COM_CLEAR:
            state_d = 1'b1;
          `TMR8_COM_SET:
            state_d = 1'b0;
          default:
            state_d = state_d;
        endcase
      end
    end
    else
    begin
      if (force_strobe)
        state_d = wave_action(compare_output_mode_q, state_d);
      if (match_hit)
        state_d = wave_action(compare_output_mode_q, state_d);
    end
  end

  // Read data, valid in the cycle after the strobe
  always @*
  begin
    rdata_d = {DW{1'b0}};
    if (bus_rd)
    begin
      case (bus_addr)
        `TMR8_ADDR_CTRL:
        begin
          rdata_d[`TMR8_CTRL_WM_HI:`TMR8_CTRL_WM_LO]   = waveform_mode_q;
          rdata_d[`TMR8_CTRL_COM_HI:`TMR8_CTRL_COM_LO] = compare_output_mode_q;
        end
        `TMR8_ADDR_COUNT:
          rdata_d = counter_value_q;
        `TMR8_ADDR_COMPARE:
          rdata_d = compare_buf_q;
        `TMR8_ADDR_FLAGS:
        begin
          rdata_d[`TMR8_FLAG_OVF] = ovf_q;
          rdata_d[`TMR8_FLAG_CMP] = cmp_q;
        end
        `TMR8_ADDR_PIN:
        begin
          rdata_d[`TMR8_PIN_DIR]   = dir_q;
          rdata_d[`TMR8_PIN_PORT]  = port_q;
          rdata_d[`TMR8_PIN_STATE] = state_q;
        end
        default:
          rdata_d = {DW{1'b0}};
      endcase
    end
  end

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      waveform_mode_q       <= `TMR8_RST_MODE;
      compare_output_mode_q <= `TMR8_RST_MODE;
      counter_value_q       <= `TMR8_RST_BYTE;
      compare_value_q       <= `TMR8_RST_BYTE;
      compare_buf_q         <= `TMR8_RST_BYTE;
      block_q               <= 1'b0;
      ovf_q                 <= 1'b0;
      cmp_q                 <= 1'b0;
      state_q               <= 1'b0;
      dir_q                 <= 1'b0;
      port_q                <= 1'b0;
      pin_out_q             <= 1'b0;
      pin_oe_q              <= 1'b0;
      rdata_q               <= `TMR8_RST_BYTE;
    end
    else
    begin
      if (wr_ctrl)
      begin
        waveform_mode_q       <= bus_wdata[`TMR8_CTRL_WM_HI:`TMR8_CTRL_WM_LO];
        compare_output_mode_q <= bus_wdata[`TMR8_CTRL_COM_HI:`TMR8_CTRL_COM_LO];
      end
      if (wr_pin)
      begin
        dir_q  <= bus_wdata[`TMR8_PIN_DIR];
        port_q <= bus_wdata[`TMR8_PIN_PORT];
      end
      counter_value_q <= counter_value_d;
      compare_value_q <= compare_value_d;
      compare_buf_q   <= compare_buf_d;
      block_q         <= block_d;
      ovf_q           <= ovf_d;
      cmp_q           <= cmp_d;
      state_q         <= state_d;
      // Pin registered once more; lags the state by a cycle
      pin_out_q       <= override ? state_q : port_q;
      pin_oe_q        <= dir_q;
      rdata_q         <= rdata_d;
    end
  end

  assign bus_rdata            = rdata_q;
  assign overflow_flag        = ovf_q;
  assign compare_match_flag   = cmp_q;
  assign compare_output_state = state_q;
  assign pin_out              = pin_out_q;
  assign pin_oe               = pin_oe_q;

endmodule

// ==== tmr8_load.sv ====
`timescale 1ns/1ps
module tmr8_load
(
  input  wire ref_clk,
  input  wire pin_out,
  input  wire pin_oe,
  output reg  pin_level
);
  initial pin_level = 1'b0;
  // Undriven pin flips each cycle so a stale level never passes
  always @(posedge ref_clk)
    pin_level <= pin_oe ? pin_out : ~pin_level;
endmodule

// ==== tmr8_wave_props.sv ====
`timescale 1ns/1ps
`include "tmr8_regs.vh"
module tmr8_chk
#(
  parameter DW = 8
)
(
  input wire                ref_clk,
  input wire                rstn,
  input wire                tick_en,
  input wire [`TMR8_AW-1:0] bus_addr,
  input wire [DW-1:0]       bus_wdata,
  input wire                bus_wr,
  input wire                bus_rd,
  input wire [DW-1:0]       bus_rdata,
  input wire                ovf_ack,
  input wire                cmp_ack,
  input wire                overflow_flag,
  input wire                compare_match_flag,
  input wire                compare_output_state,
  input wire                pin_out,
  input wire                pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire fw = bus_wr && bus_addr == `TMR8_ADDR_FLAGS;
  wire cw = bus_wr && bus_addr == `TMR8_ADDR_CTRL;
  chk_reset_clear: assert property ($rose(rstn) |-> !compare_output_state)
    else $error("state not clear after reset");
  chk_ovf_held: assert property (overflow_flag && !ovf_ack && !(fw && bus_wdata[0]) |=> overflow_flag)
    else $error("overflow flag dropped");
  chk_ovf_ack_clr: assert property (ovf_ack && !tick_en |=> !overflow_flag)
    else $error("overflow flag not cleared");
  chk_cmp_ack_clr: assert property (cmp_ack && !tick_en |=> !compare_match_flag)
    else $error("compare flag not cleared");
  chk_ovf_on_tick: assert property ($rose(overflow_flag) |-> $past(tick_en))
    else $error("overflow without tick");
  chk_cmp_on_tick: assert property ($rose(compare_match_flag) |-> $past(tick_en))
    else $error("compare flag without tick");
  chk_force_no_flag: assert property (cw && bus_wdata[7] && !tick_en && !compare_match_flag
    |=> !compare_match_flag)
    else $error("force set compare flag");
  chk_state_cause: assert property ($changed(compare_output_state) |-> $past(tick_en) || $past(cw))
    else $error("state moved without cause");
  chk_oe_follow: assert property (bus_wr && bus_addr == `TMR8_ADDR_PIN
    |-> ##2 pin_oe == $past(bus_wdata[0], 2))
    else $error("pin enable not direction");
endmodule

bind tmr8_wave tmr8_chk #(.DW(DW)) u_chk (.*);

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "tmr8_regs.vh"
module testbench;
  localparam [2:0] CT = `TMR8_ADDR_CTRL;
  localparam [2:0] CN = `TMR8_ADDR_COUNT;
  localparam [2:0] CP = `TMR8_ADDR_COMPARE;
  localparam [2:0] FL = `TMR8_ADDR_FLAGS;
  localparam [2:0] PN = `TMR8_ADDR_PIN;
  reg        ref_clk = 1'b0;
  reg        rstn = 1'b0;
  reg        tick_en = 1'b0;
  reg  [2:0] bus_addr = 3'h0;
  reg  [7:0] bus_wdata = 8'h00;
  reg        bus_wr = 1'b0;
  reg        bus_rd = 1'b0;
  reg        ovf_ack = 1'b0;
  reg        cmp_ack = 1'b0;
  wire [7:0] bus_rdata;
  wire       ovf;
  wire       cmf;
  wire       st;
  wire       pin_out;
  wire       pin_oe;
  wire       pin_level;
  integer    n_errors = 0;
  integer    compares = 0;

  tmr8_wave dut
  (
    .ref_clk(ref_clk), .rstn(rstn), .tick_en(tick_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ovf_ack(ovf_ack), .cmp_ack(cmp_ack), .overflow_flag(ovf), .compare_match_flag(cmf),
    .compare_output_state(st), .pin_out(pin_out), .pin_oe(pin_oe)
  );
  tmr8_load load
  (
    .ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level)
  );

  initial forever #4 ref_clk = ~ref_clk;

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      #1;
    end
  endtask

  task rd(input [2:0] a, input [7:0] e);
    begin
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1;
      chk(bus_rdata, e);
    end
  endtask

  task tk(input integer n);
    begin
      @(posedge ref_clk);
      tick_en <= 1'b1;
      repeat (n) @(posedge ref_clk);
      tick_en <= 1'b0;
      #1;
    end
  endtask

  // Pin path lags state by a register and the load by one more
  task settle;
    begin
      repeat (3) @(posedge ref_clk);
      #1;
    end
  endtask

  task conclude;
    begin
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  initial
  begin
    #40000;
    n_errors = n_errors + 1;
    conclude;
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk(st, 0);
    rd(CT, 0);
    rd(3'h5, 0);
    $display("reset done");
    wr(CN, 8'hFE);
    tk(2);
    chk(ovf, 1);
    rd(CN, 0);
    rd(FL, 1);
    @(posedge ref_clk);
    ovf_ack <= 1'b1;
    @(posedge ref_clk);
    ovf_ack <= 1'b0;
    rd(FL, 0);
    $display("normal done");
    wr(CT, 8'h06);
    wr(CP, 3);
    wr(CN, 0);
    tk(4);
    chk(st, 1);
    chk(cmf, 1);
    rd(CN, 0);
    rd(FL, 2);
    @(posedge ref_clk);
    cmp_ack <= 1'b1;
    @(posedge ref_clk);
    cmp_ack <= 1'b0;
    #1;
    chk(cmf, 0);
    wr(FL, 3);
    wr(CT, 8'h86);
    chk(st, 0);
    rd(FL, 0);
    wr(CT, 8'h02);
    tk(4);
    chk(st, 0);
    rd(FL, 2);
    wr(FL, 3);
    wr(CN, 3);
    tk(1);
    rd(CN, 4);
    rd(FL, 0);
    tk(252);
    rd(FL, 1);
    rd(CN, 0);
    $display("clear on match done");
    wr(PN, 8'h03);
    settle;
    chk(pin_level, 1);
    wr(CT, 8'h0F);
    settle;
    chk(pin_level, 0);
    wr(CT, 8'h8F);
    chk(st, 0);
    wr(PN, 8'h02);
    settle;
    chk(pin_oe, 0);
    $display("pin done");
    wr(CT, 8'h0B);
    wr(CP, 8'h80);
    wr(FL, 3);
    wr(CN, 8'hFE);
    tk(2);
    chk(st, 1);
    rd(FL, 1);
    rd(CN, 0);
    wr(CP, 8'h10);
    wr(CN, 8'h7F);
    tk(2);
    chk(st, 0);
    rd(FL, 3);
    // Compare zero gives a one-tick spike after bottom
    wr(CP, 8'h00);
    wr(CN, 8'hFE);
    tk(2);
    chk(st, 1);
    tk(1);
    chk(st, 0);
    // Compare at maximum holds one level for a whole period
    wr(CP, 8'hFF);
    wr(CN, 8'hFE);
    tk(2);
    chk(st, 1);
    tk(256);
    chk(st, 1);
    wr(CT, 8'h0F);
    tk(256);
    chk(st, 0);
    $display("fast pwm done");
    // Unbuilt phase mode counts like normal and raises no overflow
    wr(CT, 8'h01);
    wr(FL, 3);
    wr(CN, 8'hFF);
    tk(1);
    rd(CN, 0);
    chk(ovf, 0);
    // Force uses the mode already held, so set it first
    wr(CT, 8'h0D);
    wr(CT, 8'h8D);
    chk(st, 1);
    wr(CT, 8'h09);
    wr(CT, 8'h89);
    chk(st, 0);
    wr(CT, 8'h0D);
    wr(CT, 8'h8D);
    chk(st, 1);
    chk(cmf, 0);
    $display("phase and force done");
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    chk(st, 0);
    rd(CN, 0);
    rd(PN, 0);
    $display("mid-run reset done");
    conclude;
  end
endmodule
